// File: bcsr_router.sv
// boot chip select router with nor bank toggle and shared latch
// Behaviour
// - codes 0-7: nor cs0, emulator cs1, nand 2,4-6
// - code 8: emulator cs0, nor cs1, unbanked
// - code 9: nand cs0,4-6, nor cs2, emulator cs1
// - chip select zero steered to chosen boot device
// - xor nor address a23-a25 with map bits
// - switch changes among codes 0-7 toggle nor banks, code 9 moves nand selects
// - 16-bit upper address latch, separate write and read data buffers
// - sd upper data and spi selects exclusive
// - gpio 0-1 mux one, 2-3 mux two
// - drive usb phy id for peripheral mode
`timescale 1ns/10ps
`include "bcsr_defs.svh"
module bcsr_router
    import bcsr_pkg::*;
#(
    parameter int ADDR_W = `BCSR_ADDR_W,
    parameter int DATA_W = `BCSR_DATA_W,
    parameter int NCS = `BCSR_NCS
) (
    input wire logic i_clock, // 50 MHz system clock
    input wire logic i_rst_n, // async reset, active low
    input wire logic i_ce, // clock enable, freezes state when low
    input wire logic [3:0] i_map, // boot map switches
    input wire logic [NCS-1:0] i_lb_cs_n, // chip selects from bus controller
    input wire logic [ADDR_W-1:0] i_lb_addr, // bus address toward nor
    input wire logic i_lb_ale, // address latch enable
    input wire logic [DATA_W-1:0] i_lb_ad_in, // shared addr/data from bus
    input wire logic [DATA_W-1:0] i_flash_d_in, // data back from flash
    input wire logic i_lb_rd_n, // read strobe, active low
    input wire logic i_sd_wide_sel, // 1: sd owns the shared pins
    input wire logic [3:0] i_spi_cs_n, // spi selects from controller
    input wire logic [3:0] i_sd_dat_out, // sd upper data out
    input wire logic [3:0] i_sd_dat_oe, // sd upper data enables
    input wire logic [3:0] i_shared_in, // shared pin levels
    input wire logic [7:0] i_gpio, // processor gpio
    input wire logic i_usb_periph, // request peripheral mode
    output logic [NCS-1:0] o_nor_cs_n, // nor select, bit 0 only used
    output logic o_nor_ce_n, // nor chip enable, active low
    output logic o_emu_ce_n, // emulator port enable, active low
    output logic [3:0] o_nand_ce_n, // nand enables, active low
    output logic [ADDR_W-1:0] o_nor_addr, // address to nor with toggle
    output logic [DATA_W-1:0] o_latch_addr, // latched upper address
    output logic [DATA_W-1:0] o_buf_to_flash, // buffered write data
    output logic [DATA_W-1:0] o_buf_to_bus, // buffered read data
    output logic [3:0] o_sd_dat_in, // shared pins to sd controller
    output logic [3:0] o_shared_out, // shared pin drive
    output logic [3:0] o_shared_oe, // shared pin enable
    output logic [1:0] o_em1_mux_sel, // first management mux select
    output logic [1:0] o_em2_mux_sel, // second management mux select
    output logic [3:0] o_gpio_spare, // spare gpio to test points
    output logic o_usb_id, // usb phy id, low = host
    output bcsr_route_t o_route // active route, from a register
);
    logic [3:0] map_r;
    logic [3:0] map_eff;
    bcsr_route_t route_nxt;
    bcsr_route_t route_r;
    logic [`BCSR_BANK_W-1:0] bank_bits;
    logic [`BCSR_BANK_W-1:0] addr_hi_tog;
    logic [DATA_W-1:0] latch_r;
    logic [DATA_W-1:0] wbuf_r;
    logic [DATA_W-1:0] rbuf_r;
    logic usb_id_r;
    logic [1:0] em1_r;
    logic [1:0] em2_r;

    // invalid codes folded to the default so no select is left floating
    always_comb begin
        if (i_map > `BCSR_MAP_LAST_VALID) begin
            map_eff = `BCSR_MAP_DEFAULT;
        end else begin
            map_eff = i_map;
        end
    end

    // map sampled once per enabled edge so routing never glitches mid-cycle
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            map_r <= `BCSR_MAP_DEFAULT;
        end else if (i_ce) begin
            map_r <= map_eff;
        end
    end

    // decode route from the held code
    always_comb begin
        if (map_r == `BCSR_MAP_EMU) begin
            route_nxt = BCSR_EMU_BOOT;
        end else if (map_r == `BCSR_MAP_NAND) begin
            route_nxt = BCSR_NAND_BOOT;
        end else begin
            route_nxt = BCSR_NOR_BOOT;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            route_r <= BCSR_NOR_BOOT;
        end else if (i_ce) begin
            route_r <= route_nxt;
        end
    end

    assign o_route = route_r;

    // select steering; cs0 always lands on the boot device
    always_comb begin
        o_nor_ce_n = 1'b1;
        o_emu_ce_n = 1'b1;
        o_nand_ce_n = 4'hf;
        unique case (route_r)
            BCSR_NOR_BOOT: begin
                o_nor_ce_n = i_lb_cs_n[0];
                o_emu_ce_n = i_lb_cs_n[1];
                o_nand_ce_n = {i_lb_cs_n[6:4], i_lb_cs_n[2]};
            end
            BCSR_EMU_BOOT: begin
                o_emu_ce_n = i_lb_cs_n[0];
                o_nor_ce_n = i_lb_cs_n[1];
                o_nand_ce_n = {i_lb_cs_n[6:4], i_lb_cs_n[2]};
            end
            BCSR_NAND_BOOT: begin
                o_nand_ce_n = {i_lb_cs_n[6:4], i_lb_cs_n[0]};
                o_nor_ce_n = i_lb_cs_n[2];
                o_emu_ce_n = i_lb_cs_n[1];
            end
            default: begin
                o_nor_ce_n = 1'b1;
            end
        endcase
    end

    assign o_nor_cs_n = {{(NCS-1){1'b1}}, o_nor_ce_n};

    // banking only when nor is the boot device; low map bits pick region
    assign bank_bits = (route_r == BCSR_NOR_BOOT) ? map_r[2:0] : 3'h0;

    bcsr_addr_toggle #(
        .BANK_W(`BCSR_BANK_W)
    ) u_toggle (
        .i_addr_hi(i_lb_addr[ADDR_W-1:`BCSR_BANK_LSB]),
        .i_map_bits(bank_bits),
        .o_addr_hi(addr_hi_tog)
    );

    // a map change among codes 0-7 flips an address half/quarter/eighth, the nand lines via route
    assign o_nor_addr = {addr_hi_tog, i_lb_addr[`BCSR_BANK_LSB-1:0]};

    // address latch, kept separate from the data buffer registers
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            latch_r <= '0;
        end else if (i_ce && i_lb_ale) begin
            latch_r <= i_lb_ad_in;
        end
    end

    // data buffer registers; one cycle of latency traded for clean edges
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wbuf_r <= '0;
            rbuf_r <= '0;
        end else if (i_ce && !i_lb_ale) begin
            if (i_lb_rd_n) begin
                wbuf_r <= i_lb_ad_in;
            end else begin
                rbuf_r <= i_flash_d_in;
            end
        end
    end

    assign o_latch_addr = latch_r;
    assign o_buf_to_flash = wbuf_r;
    assign o_buf_to_bus = rbuf_r;

    // shared pins: exactly one owner, never both drivers at once
    always_comb begin
        if (i_sd_wide_sel) begin
            o_shared_out = i_sd_dat_out;
            o_shared_oe = i_sd_dat_oe;
            o_sd_dat_in = i_shared_in;
        end else begin
            o_shared_out = i_spi_cs_n;
            o_shared_oe = 4'hf;
            o_sd_dat_in = 4'hf; // sd sees idle-high data
        end
    end

    // mux selects registered so a gpio glitch does not switch a bus mid-frame
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            em1_r <= 2'h0;
            em2_r <= 2'h0;
        end else if (i_ce) begin
            em1_r <= i_gpio[1:0];
            em2_r <= i_gpio[3:2];
        end
    end

    assign o_em1_mux_sel = em1_r;
    assign o_em2_mux_sel = em2_r;
    assign o_gpio_spare = i_gpio[7:4];

    // id high selects peripheral role; resets to host
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            usb_id_r <= 1'b0;
        end else if (i_ce) begin
            usb_id_r <= i_usb_periph;
        end
    end

    assign o_usb_id = usb_id_r;

    // cs0 always reaches the decoded boot device
    chk_cs0_boot_dev: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (route_r == BCSR_EMU_BOOT) |-> (o_emu_ce_n == i_lb_cs_n[0]))
        else $error("cs0 not on emulator");
    chk_nor_route: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (route_r == BCSR_NOR_BOOT) |-> (o_nor_ce_n == i_lb_cs_n[0]
        && o_emu_ce_n == i_lb_cs_n[1]))
        else $error("nor route wrong");
    chk_nand_route: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (route_r == BCSR_NAND_BOOT) |-> (o_nand_ce_n[0] == i_lb_cs_n[0]
        && o_nor_ce_n == i_lb_cs_n[2]))
        else $error("nand route wrong");
    chk_invalid_fallback: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (i_ce && i_map > `BCSR_MAP_LAST_VALID) |=> (map_r == `BCSR_MAP_DEFAULT))
        else $error("invalid code not defaulted");
    chk_emu_unbanked: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (route_r == BCSR_EMU_BOOT) |-> (o_nor_addr == i_lb_addr))
        else $error("nor banked in emulator boot");
    chk_bank_toggle: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (route_r == BCSR_NOR_BOOT) |-> (o_nor_addr[ADDR_W-1:`BCSR_BANK_LSB]
        == (i_lb_addr[ADDR_W-1:`BCSR_BANK_LSB] ^ map_r[2:0])))
        else $error("bank xor wrong");
    chk_latch_capture: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (i_ce && i_lb_ale) |=> (o_latch_addr == $past(i_lb_ad_in)))
        else $error("latch missed address");
    chk_shared_excl: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (!i_sd_wide_sel) |-> (o_shared_out == i_spi_cs_n && o_sd_dat_in == 4'hf))
        else $error("shared pins double owned");
    chk_mux_sel: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_ce |=> (o_em1_mux_sel == $past(i_gpio[1:0])
        && o_em2_mux_sel == $past(i_gpio[3:2])))
        else $error("mux select wrong");
    chk_usb_id: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_ce |=> (o_usb_id == $past(i_usb_periph)))
        else $error("usb id not driven");

    // route change takes two enabled edges: code captured, then route follows
    sequence s_emu_code_taken;
        i_ce && (i_map == `BCSR_MAP_EMU);
    endsequence
    sequence s_nand_code_taken;
        i_ce && (i_map == `BCSR_MAP_NAND);
    endsequence
    chk_emu_two_step: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        s_emu_code_taken ##1 i_ce |=> (o_route == BCSR_EMU_BOOT))
        else $error("emulator route not taken");
    chk_nand_two_step: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        s_nand_code_taken ##1 i_ce |=> (o_route == BCSR_NAND_BOOT))
        else $error("nand route not taken");

    // the selects that do not boot still land where the map says
    chk_nor_nand_sel: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (route_r == BCSR_NOR_BOOT)
        |-> (o_nand_ce_n == {i_lb_cs_n[6:4], i_lb_cs_n[2]}))
        else $error("nand selects wrong in nor route");
    chk_emu_other_sel: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (route_r == BCSR_EMU_BOOT) |-> (o_nor_ce_n == i_lb_cs_n[1]
        && o_nand_ce_n == {i_lb_cs_n[6:4], i_lb_cs_n[2]}))
        else $error("selects wrong in emulator route");
    chk_nand_full_sel: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (route_r == BCSR_NAND_BOOT) |-> (o_nand_ce_n == {i_lb_cs_n[6:4], i_lb_cs_n[0]}
        && o_emu_ce_n == i_lb_cs_n[1]))
        else $error("selects wrong in nand route");
    chk_nand_unbanked: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (route_r == BCSR_NAND_BOOT) |-> (o_nor_addr == i_lb_addr))
        else $error("nor banked in nand boot");

    // both halves of the shared buffer, and the latch holding between captures
    chk_wbuf_capture: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (i_ce && !i_lb_ale && i_lb_rd_n) |=> (o_buf_to_flash == $past(i_lb_ad_in)))
        else $error("write buffer missed data");
    chk_rbuf_capture: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        (i_ce && !i_lb_ale && !i_lb_rd_n) |=> (o_buf_to_bus == $past(i_flash_d_in)))
        else $error("read buffer missed data");
    chk_latch_hold: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        !(i_ce && i_lb_ale) |=> $stable(o_latch_addr))
        else $error("latch changed without capture");

    // sd ownership passes its own drive straight through
    chk_sd_owner: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        i_sd_wide_sel |-> (o_shared_out == i_sd_dat_out && o_shared_oe == i_sd_dat_oe
        && o_sd_dat_in == i_shared_in))
        else $error("sd does not own shared pins");
    chk_spare_pins: assert property (@(posedge i_clock) disable iff (!i_rst_n)
        1'b1 |-> (o_gpio_spare == i_gpio[7:4]))
        else $error("spare gpio not passed");
endmodule

// File: bcsr_defs.svh
// constants for the boot chip select router
`ifndef BCSR_DEFS_SVH
`define BCSR_DEFS_SVH
`define BCSR_MAP_W 4
`define BCSR_NCS 7
`define BCSR_MAP_EMU 4'h8
`define BCSR_MAP_NAND 4'h9
`define BCSR_MAP_LAST_VALID 4'h9
`define BCSR_MAP_DEFAULT 4'h0
`define BCSR_CS_IDLE 7'h7f
`define BCSR_BANK_W 3
`define BCSR_ADDR_W 26
`define BCSR_BANK_LSB 23
`define BCSR_DATA_W 16
`endif

// File: bcsr_pkg.sv
// types for the boot chip select router
`include "bcsr_defs.svh"
package bcsr_pkg;
    typedef enum logic [2:0] {
        BCSR_NOR_BOOT = 3'b001,
        BCSR_EMU_BOOT = 3'b010,
        BCSR_NAND_BOOT = 3'b100
    } bcsr_route_t;
endpackage

// File: bcsr_addr_toggle.sv
// staged xor of the upper nor address bits with the map bits
`timescale 1ns/10ps
`include "bcsr_defs.svh"
module bcsr_addr_toggle #(
    parameter int BANK_W = `BCSR_BANK_W
) (
    input wire logic [BANK_W-1:0] i_addr_hi, // upper nor address bits
    input wire logic [BANK_W-1:0] i_map_bits, // encoded bank select
    output logic [BANK_W-1:0] o_addr_hi // toggled address bits
);
    // one xor stage per address bit, in series with the flash address
    genvar g;
    generate
        for (g = 0; g < BANK_W; g++) begin : g_stage
            assign o_addr_hi[g] = i_addr_hi[g] ^ i_map_bits[g];
        end
    endgenerate
endmodule

// File: bcsr_flash_model.sv
// behavioural nor flash answering reads on the router's select
`timescale 1ns/10ps
module bcsr_flash_model (
    input wire logic i_clock, // system clock
    input wire logic i_ce_n, // nor chip enable from router
    input wire logic i_rd_n, // read strobe, active low
    input wire logic [15:0] i_addr, // low address bits
    output logic [15:0] o_data // read data to router
);
    logic [15:0] last_r = 16'h0000;
    // released bus shows the inverse of the last word, never a stale copy
    assign o_data = (!i_ce_n && !i_rd_n) ? (i_addr ^ 16'h5a5a) : ~last_r;
    // remember the driven word so the idle pattern keeps moving
    always @(posedge i_clock) begin
        last_r <= o_data;
    end
endmodule

// File: test_boot_chip_select_router.sv
// self-checking bench for the boot chip select router
`timescale 1ns/10ps
module test_boot_chip_select_router
    import bcsr_pkg::*;
;
    logic i_clock = 0, i_rst_n = 0, i_ce = 1, i_lb_ale = 0, i_lb_rd_n = 1;
    logic i_sd_wide_sel = 0, i_usb_periph = 0;
    logic [3:0] i_map = 0, i_spi_cs_n = 0, i_sd_dat_out = 0, i_sd_dat_oe = 0, i_shared_in = 0;
    logic [6:0] i_lb_cs_n = 7'h7f;
    logic [25:0] i_lb_addr = 0;
    logic [15:0] i_lb_ad_in = 0, i_flash_d_in, e_lat = 0, e_wb = 0, e_rb = 0;
    logic [7:0] i_gpio = 0;
    logic [5:0] e_sel = 0;
    logic [6:0] o_nor_cs_n;
    logic o_nor_ce_n, o_emu_ce_n, o_usb_id;
    logic [3:0] o_nand_ce_n, o_sd_dat_in, o_shared_out, o_shared_oe, o_gpio_spare;
    logic [25:0] o_nor_addr;
    logic [15:0] o_latch_addr, o_buf_to_flash, o_buf_to_bus;
    logic [1:0] o_em1_mux_sel, o_em2_mux_sel;
    bcsr_route_t o_route;
    int mismatches = 0, checks = 0;
    logic [31:0] seed = 32'd51, r;

    bcsr_router i_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_map(i_map),
        .i_lb_cs_n(i_lb_cs_n), .i_lb_addr(i_lb_addr), .i_lb_ale(i_lb_ale),
        .i_lb_ad_in(i_lb_ad_in), .i_flash_d_in(i_flash_d_in), .i_lb_rd_n(i_lb_rd_n),
        .i_sd_wide_sel(i_sd_wide_sel), .i_spi_cs_n(i_spi_cs_n), .i_sd_dat_out(i_sd_dat_out),
        .i_sd_dat_oe(i_sd_dat_oe), .i_shared_in(i_shared_in), .i_gpio(i_gpio),
        .i_usb_periph(i_usb_periph), .o_nor_cs_n(o_nor_cs_n), .o_nor_ce_n(o_nor_ce_n),
        .o_emu_ce_n(o_emu_ce_n), .o_nand_ce_n(o_nand_ce_n), .o_nor_addr(o_nor_addr),
        .o_latch_addr(o_latch_addr), .o_buf_to_flash(o_buf_to_flash),
        .o_buf_to_bus(o_buf_to_bus), .o_sd_dat_in(o_sd_dat_in), .o_shared_out(o_shared_out),
        .o_shared_oe(o_shared_oe), .o_em1_mux_sel(o_em1_mux_sel),
        .o_em2_mux_sel(o_em2_mux_sel), .o_gpio_spare(o_gpio_spare), .o_usb_id(o_usb_id),
        .o_route(o_route));
    bcsr_flash_model i_flash (.i_clock(i_clock), .i_ce_n(o_nor_ce_n), .i_rd_n(i_lb_rd_n),
        .i_addr(o_nor_addr[15:0]), .o_data(i_flash_d_in));

    // 50 MHz clock
    always #10 i_clock = ~i_clock;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // expected {nor, emulator, nand[3:0]} enables for a map code
    function automatic logic [5:0] exp_sel(input logic [3:0] m, input logic [6:0] c);
        if (m == 4'h8) return {c[1], c[0], c[6:4], c[2]};
        if (m == 4'h9) return {c[2], c[1], c[6:4], c[0]};
        return {c[0], c[1], c[6:4], c[2]};
    endfunction
    function automatic bcsr_route_t exp_route(input logic [3:0] m);
        return (m == 4'h8) ? BCSR_EMU_BOOT : (m == 4'h9) ? BCSR_NAND_BOOT : BCSR_NOR_BOOT;
    endfunction
    // invalid codes fall back to bank 0, so only codes below 8 bank
    function automatic logic [25:0] exp_addr(input logic [3:0] m, input logic [25:0] a);
        return (m < 4'h8) ? {a[25:23] ^ m[2:0], a[22:0]} : a;
    endfunction
    task automatic note(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cmp_sel(input logic [7:0] got, input logic [7:0] exp);
        note(32'(got), 32'(exp));
    endtask
    task automatic cmp_addr(input logic [25:0] got, input logic [25:0] exp);
        note(32'(got), 32'(exp));
    endtask
    task automatic cmp_data(input logic [15:0] got, input logic [15:0] exp);
        note(32'(got), 32'(exp));
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // hang guard: a run past its bound counts as a mismatch
    initial begin
        repeat (20000) @(posedge i_clock);
        mismatches++;
        test_done();
    end

    // main sequence, inputs change at the falling edge
    initial begin
        repeat (10) @(posedge i_clock);
        @(negedge i_clock);
        i_rst_n = 1;
        cmp_sel(8'(o_route), 8'(BCSR_NOR_BOOT));
        for (int m = 0; m < 16; m++) begin
            i_map = 4'(m);
            repeat (2) @(negedge i_clock);
            for (int k = 0; k < 4; k++) begin
                @(negedge i_clock);
                r = rnd();
                i_lb_cs_n = (k == 0) ? 7'h7e : r[6:0];
                i_lb_addr = r[31:6];
                #1;
                e_sel = exp_sel(i_map, i_lb_cs_n);
                cmp_sel({2'b00, o_nor_ce_n, o_emu_ce_n, o_nand_ce_n}, 8'(e_sel));
                cmp_sel(8'(o_nor_cs_n), {1'b0, 6'h3f, e_sel[5]});
                cmp_sel(8'(o_route), 8'(exp_route(i_map)));
                cmp_addr(o_nor_addr, exp_addr(i_map, i_lb_addr));
            end
        end
        $display("test routing done");
        // back-to-back latch, write and read cycles on the shared buffer
        i_map = 4'h0;
        i_lb_cs_n = 7'h7e;
        repeat (2) @(negedge i_clock);
        for (int k = 0; k < 24; k++) begin
            r = rnd();
            i_lb_ale = (k % 3 == 0);
            i_lb_rd_n = (k % 3 != 2);
            i_lb_ad_in = r[15:0];
            i_lb_addr = {10'h000, r[31:16]};
            if (i_lb_ale) e_lat = r[15:0];
            else if (i_lb_rd_n) e_wb = r[15:0];
            else e_rb = r[31:16] ^ 16'h5a5a;
            @(negedge i_clock);
            cmp_data(o_latch_addr, e_lat);
            cmp_data(o_buf_to_flash, e_wb);
            cmp_data(o_buf_to_bus, e_rb);
        end
        $display("test latch done");
        for (int k = 0; k < 8; k++) begin
            @(negedge i_clock);
            r = rnd();
            i_sd_wide_sel = k[0];
            {i_spi_cs_n, i_sd_dat_out, i_sd_dat_oe, i_shared_in} = r[15:0];
            #1;
            if (i_sd_wide_sel) begin
                cmp_sel({o_shared_out, o_shared_oe}, {i_sd_dat_out, i_sd_dat_oe});
                cmp_sel(8'(o_sd_dat_in), 8'(i_shared_in));
            end else begin
                cmp_sel({o_shared_out, o_shared_oe}, {i_spi_cs_n, 4'hf});
                cmp_sel(8'(o_sd_dat_in), 8'h0f);
            end
        end
        $display("test shared pins done");
        for (int k = 0; k < 6; k++) begin
            r = rnd();
            i_gpio = r[7:0];
            i_usb_periph = r[8];
            @(negedge i_clock);
            cmp_sel({o_gpio_spare, o_em2_mux_sel, o_em1_mux_sel}, i_gpio);
            cmp_sel(8'(o_usb_id), 8'(i_usb_periph));
        end
        $display("test gpio done");
        // clock enable low must hold route and latch
        i_ce = 0;
        i_map = 4'h8;
        i_lb_ale = 1;
        i_lb_ad_in = ~e_lat;
        repeat (3) @(negedge i_clock);
        cmp_sel(8'(o_route), 8'(BCSR_NOR_BOOT));
        cmp_data(o_latch_addr, e_lat);
        i_ce = 1;
        repeat (3) @(negedge i_clock);
        cmp_sel(8'(o_route), 8'(BCSR_EMU_BOOT));
        $display("test freeze done");
        test_done();
    end
endmodule
